// file: pkg/rtcie_regs.svh
// Register map, field positions and reset values of the interrupt enable block.
`ifndef RTCIE_REGS_SVH
`define RTCIE_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------------
`define RTCIE_IDX_CTRL 6'h00
`define RTCIE_IDX_EVOUT 6'h04
`define RTCIE_IDX_ENCLR 6'h06
`define RTCIE_IDX_ENSET 6'h07
`define RTCIE_IDX_FLAG 6'h08
`define RTCIE_IDX_WPROT 6'h0a

// ----------------------------------------------------------------------------
// Fields.
// ----------------------------------------------------------------------------
`define RTCIE_MODE_HI 3
`define RTCIE_MODE_LO 2
`define RTCIE_MODE_WIDE 2'h0
`define RTCIE_MODE_NARROW 2'h1
`define RTCIE_MODE_CAL 2'h2
`define RTCIE_WPROT_BIT 0
`define RTCIE_BIT_WRAP 7
`define RTCIE_BIT_SYNC 6
`define RTCIE_BIT_MATCH1 1
`define RTCIE_BIT_MATCH0 0
`define RTCIE_EN_MASK_ONE 8'hc1
`define RTCIE_EN_MASK_TWO 8'hc3
`define RTCIE_EVOUT_WRAP 15
`define RTCIE_EVOUT_MATCH_HI 9
`define RTCIE_EVOUT_MATCH_LO 8
`define RTCIE_EVOUT_PER_HI 7
`define RTCIE_EVOUT_PER_LO 0
`define RTCIE_EVOUT_MASK_ONE 16'h81ff
`define RTCIE_EVOUT_MASK_TWO 16'h83ff

// ----------------------------------------------------------------------------
// Reset values and bus answers.
// ----------------------------------------------------------------------------
`define RTCIE_RST_EN 8'h00
`define RTCIE_RST_FLAG 8'h00
`define RTCIE_RST_EVOUT 16'h0000
`define RTCIE_RST_MODE 2'h0
`define RTCIE_RESP_OKAY 2'h0
`define RTCIE_RESP_DECERR 2'h3

`endif

// file: pkg/rtcie_pkg.sv
// Types shared by the interrupt enable block.
package rtcie_pkg;
  typedef logic [1:0] rtcie_mode_type;
  typedef enum logic [0:0] {
    rtcie_rd_idle,
    rtcie_rd_resp
  } rtcie_rd_state_type;
endpackage

// file: design/rtcie_event_gate.sv
// Registered gate that passes core event pulses only while enabled.
`timescale 1ns/100ps
`default_nettype none
module rtcie_event_gate #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic [WIDTH-1:0] enable,
  output logic [WIDTH-1:0] event_out
);
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  always_comb begin
    out_next = event_in & enable;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign event_out = out_reg;
endmodule
`default_nettype wire

// file: design/rtcie_top.sv
// Interrupt enable set/clear, flags and event output gating behind AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "rtcie_regs.svh"
module rtcie_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wrap_pulse,
  input wire logic sync_done_pulse,
  input wire logic [1:0] match_pulse,
  input wire logic [7:0] period_pulse,
  output logic [1:0] mode_sel,
  output logic irq,
  output logic wrap_event_out,
  output logic [1:0] match_event_out,
  output logic [7:0] period_event_out
);

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  logic aw_got_reg;
  logic aw_got_next;
  logic w_got_reg;
  logic w_got_next;
  logic [5:0] aw_idx_reg;
  logic [5:0] aw_idx_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  rtcie_pkg::rtcie_rd_state_type rd_state_reg;
  rtcie_pkg::rtcie_rd_state_type rd_state_next;
  logic arready_reg;
  logic arready_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  rtcie_pkg::rtcie_mode_type mode_reg;
  rtcie_pkg::rtcie_mode_type mode_next;
  logic wprot_reg;
  logic wprot_next;
  logic [7:0] en_reg;
  logic [7:0] en_next;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [15:0] evout_reg;
  logic [15:0] evout_next;
  logic irq_reg;
  logic irq_next;
  logic [7:0] valid_mask;
  logic [7:0] valid_mask_next;
  logic [15:0] evout_mask;
  logic [1:0] match_gate;

  // --------------------------------------------------------------------------
  // Mode decode.
  // --------------------------------------------------------------------------
  // Only the narrow counter has a second match channel; other modes,
  // including the reserved code, use the single-channel layout.
  always_comb begin
    valid_mask = `RTCIE_EN_MASK_ONE;
    valid_mask_next = `RTCIE_EN_MASK_ONE;
    evout_mask = `RTCIE_EVOUT_MASK_ONE;
    if (mode_reg == `RTCIE_MODE_NARROW) begin
      valid_mask = `RTCIE_EN_MASK_TWO;
      evout_mask = `RTCIE_EVOUT_MASK_TWO;
    end
    if (mode_next == `RTCIE_MODE_NARROW) begin
      valid_mask_next = `RTCIE_EN_MASK_TWO;
    end
  end

  // --------------------------------------------------------------------------
  // Write channel and register updates.
  // --------------------------------------------------------------------------
  always_comb begin
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    flag_set = 8'h00;
    flag_clr = 8'h00;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    aw_idx_next = aw_idx_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    mode_next = mode_reg;
    wprot_next = wprot_reg;
    en_next = en_reg;
    evout_next = evout_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_got_next = 1'b1;
      aw_idx_next = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && wready_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_got_reg && w_got_reg && !bvalid_reg) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `RTCIE_RESP_OKAY;
      unique case (aw_idx_reg)
        `RTCIE_IDX_CTRL: begin
          if (wstrb_reg[0]) begin
            mode_next = wdata_reg[`RTCIE_MODE_HI:`RTCIE_MODE_LO];
          end
        end
        `RTCIE_IDX_WPROT: begin
          if (wstrb_reg[0]) begin
            wprot_next = wdata_reg[`RTCIE_WPROT_BIT];
          end
        end
        `RTCIE_IDX_EVOUT: begin
          if (!wprot_reg) begin
            if (wstrb_reg[0]) begin
              evout_next[7:0] = wdata_reg[7:0];
            end
            if (wstrb_reg[1]) begin
              evout_next[15:8] = wdata_reg[15:8] & evout_mask[15:8];
            end
          end
        end
        `RTCIE_IDX_ENCLR: begin
          if (!wprot_reg && wstrb_reg[0]) begin
            // Zeros in the written value keep their enable as is.
            en_next = en_reg & ~(wdata_reg[7:0] & valid_mask);
          end
        end
        `RTCIE_IDX_ENSET: begin
          if (!wprot_reg && wstrb_reg[0]) begin
            en_next = en_reg | (wdata_reg[7:0] & valid_mask);
          end
        end
        `RTCIE_IDX_FLAG: begin
          if (wstrb_reg[0]) begin
            flag_clr = wdata_reg[7:0];
          end
        end
        default: begin
          bresp_next = `RTCIE_RESP_DECERR;
        end
      endcase
    end
    awready_next = !aw_got_next && !bvalid_next;
    wready_next = !w_got_next && !bvalid_next;
    // A flag raised in the same cycle as its clear is kept.
    flag_set[`RTCIE_BIT_WRAP] = wrap_pulse;
    flag_set[`RTCIE_BIT_SYNC] = sync_done_pulse;
    flag_set[`RTCIE_BIT_MATCH0] = match_pulse[0];
    flag_set[`RTCIE_BIT_MATCH1] = match_pulse[1];
    flag_next = ((flag_reg & ~flag_clr) | flag_set) & valid_mask_next;
    irq_next = |(flag_next & en_next & valid_mask_next);
  end

  // --------------------------------------------------------------------------
  // Read channel.
  // --------------------------------------------------------------------------
  always_comb begin
    rd_state_next = rd_state_reg;
    arready_next = arready_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    unique case (rd_state_reg)
      rtcie_pkg::rtcie_rd_idle: begin
        arready_next = 1'b1;
        if (s_axi_arvalid && arready_reg) begin
          rd_state_next = rtcie_pkg::rtcie_rd_resp;
          arready_next = 1'b0;
          rdata_next = 32'h0000_0000;
          rresp_next = `RTCIE_RESP_OKAY;
          unique case (s_axi_araddr[7:2])
            `RTCIE_IDX_CTRL: begin
              rdata_next[`RTCIE_MODE_HI:`RTCIE_MODE_LO] = mode_reg;
            end
            `RTCIE_IDX_WPROT: begin
              rdata_next[`RTCIE_WPROT_BIT] = wprot_reg;
            end
            `RTCIE_IDX_EVOUT: begin
              rdata_next[15:0] = evout_reg & evout_mask;
            end
            `RTCIE_IDX_ENCLR, `RTCIE_IDX_ENSET: begin
              rdata_next[7:0] = en_reg & valid_mask;
            end
            `RTCIE_IDX_FLAG: begin
              rdata_next[7:0] = flag_reg & valid_mask;
            end
            default: begin
              rresp_next = `RTCIE_RESP_DECERR;
            end
          endcase
        end
      end
      rtcie_pkg::rtcie_rd_resp: begin
        arready_next = 1'b0;
        if (s_axi_rready) begin
          rd_state_next = rtcie_pkg::rtcie_rd_idle;
          arready_next = 1'b1;
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RTCIE_RESP_OKAY;
      rd_state_reg <= rtcie_pkg::rtcie_rd_idle;
      arready_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RTCIE_RESP_OKAY;
      mode_reg <= `RTCIE_RST_MODE;
      wprot_reg <= 1'b0;
      en_reg <= `RTCIE_RST_EN;
      flag_reg <= `RTCIE_RST_FLAG;
      evout_reg <= `RTCIE_RST_EVOUT;
      irq_reg <= 1'b0;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      aw_idx_reg <= aw_idx_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rd_state_reg <= rd_state_next;
      arready_reg <= arready_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      mode_reg <= mode_next;
      wprot_reg <= wprot_next;
      en_reg <= en_next;
      flag_reg <= flag_next;
      evout_reg <= evout_next;
      irq_reg <= irq_next;
    end
  end

  // --------------------------------------------------------------------------
  // Event outputs.
  // --------------------------------------------------------------------------
  // Second match channel exists only in the narrow counter mode.
  always_comb begin
    match_gate = evout_reg[`RTCIE_EVOUT_MATCH_HI:`RTCIE_EVOUT_MATCH_LO]
      & evout_mask[`RTCIE_EVOUT_MATCH_HI:`RTCIE_EVOUT_MATCH_LO];
  end

  rtcie_event_gate #(.WIDTH(1)) u_wrap_gate (
    .core_clk(core_clk),
    .rst(rst),
    .event_in(wrap_pulse),
    .enable(evout_reg[`RTCIE_EVOUT_WRAP]),
    .event_out(wrap_event_out)
  );

  rtcie_event_gate #(.WIDTH(2)) u_match_gate (
    .core_clk(core_clk),
    .rst(rst),
    .event_in(match_pulse),
    .enable(match_gate),
    .event_out(match_event_out)
  );

  rtcie_event_gate #(.WIDTH(8)) u_period_gate (
    .core_clk(core_clk),
    .rst(rst),
    .event_in(period_pulse),
    .enable(evout_reg[`RTCIE_EVOUT_PER_HI:`RTCIE_EVOUT_PER_LO]),
    .event_out(period_event_out)
  );

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = (rd_state_reg == rtcie_pkg::rtcie_rd_resp);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign mode_sel = mode_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// file: sim/rtcie_top_props.sv
// Concurrent checks on the ports of the interrupt enable block.
`timescale 1ns/100ps
`default_nettype none
`include "rtcie_regs.svh"
module rtcie_top_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic wrap_pulse,
  input wire logic sync_done_pulse,
  input wire logic [1:0] match_pulse,
  input wire logic [7:0] period_pulse,
  input wire logic [1:0] mode_sel,
  input wire logic irq,
  input wire logic wrap_event_out,
  input wire logic [1:0] match_event_out,
  input wire logic [7:0] period_event_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  wrap_gate_a: assert property (wrap_event_out |-> $past(wrap_pulse))
    else $error("overflow event without overflow pulse");
  alarm_gate_a: assert property (match_event_out[0] |-> $past(match_pulse[0]))
    else $error("alarm event without alarm pulse");
  period_gate_a: assert property ((period_event_out & ~$past(period_pulse)) == 8'h00)
    else $error("periodic event without periodic pulse");
  // Compare channel one exists only in the narrow layout.
  match_one_a: assert property (match_event_out[1] |-> $past(mode_sel) == `RTCIE_MODE_NARROW)
    else $error("channel one event outside narrow mode");
  reset_quiet_a: assert property ($past(rst) |-> !irq && !s_axi_bvalid && !s_axi_arready)
    else $error("outputs not quiet after reset");
  irq_cause_a: assert property ($rose(irq) |->
    $past(wrap_pulse || sync_done_pulse || (|match_pulse)) || $rose(s_axi_bvalid))
    else $error("interrupt raised without a cause");
  read_hold_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  write_resp_a: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
    else $error("write answered before both halves taken");
  cover property (irq);
  cover property (wrap_event_out);
  cover property (match_event_out[1]);
endmodule
bind rtcie_top rtcie_top_props u_props (.core_clk, .rst, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .wrap_pulse, .sync_done_pulse, .match_pulse,
  .period_pulse, .mode_sel, .irq, .wrap_event_out, .match_event_out, .period_event_out);
`default_nettype wire

// file: sim/tb_rtc_irq_event_enable.sv
// Self-checking bench for the interrupt enable block.
`timescale 1ns/100ps
`default_nettype none
`include "rtcie_regs.svh"
module tb_rtc_irq_event_enable;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, wrap_pulse = 1'b0, sync_done_pulse = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, period_pulse = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] match_pulse = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic wrap_event_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode_sel, match_event_out;
  logic [31:0] s_axi_rdata;
  logic [7:0] period_event_out;
  logic [33:0] exp_q[$];
  logic [15:0] ev_en, ev_m;
  int n_mismatch = 0, compares = 0, cycles = 0;
  always #2.5 core_clk = ~core_clk;
  rtcie_top dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wrap_pulse, .sync_done_pulse, .match_pulse, .period_pulse, .mode_sel, .irq,
    .wrap_event_out, .match_event_out, .period_event_out);
  // ------------------------------------------
  // Tasks.
  // ------------------------------------------
  task automatic test_done();
    $display("Counts: compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected answers are queued; the watcher compares each one when its response is taken.
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    exp_q.push_back({32'h0, er});
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx, input logic [33:0] exp);
    @(posedge core_clk);
    exp_q.push_back(exp);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic step(input logic [5:0] idx, input logic [7:0] d, input logic [7:0] e);
    wr(idx, {24'h0, d}, `RTCIE_RESP_OKAY);
    rd(`RTCIE_IDX_ENCLR, {26'h0, e});
  endtask
  // Bit 14 of the pulse word drives the sync event, which has no event output.
  task automatic evt(input logic [15:0] en, input logic [15:0] p, input logic [15:0] m);
    @(posedge core_clk);
    wrap_pulse <= p[15];
    sync_done_pulse <= p[14];
    match_pulse <= p[9:8];
    period_pulse <= p[7:0];
    @(posedge core_clk);
    wrap_pulse <= 1'b0;
    sync_done_pulse <= 1'b0;
    match_pulse <= 2'h0;
    period_pulse <= 8'h00;
    #1;
    chk({18'h0, wrap_event_out, 5'h0, match_event_out, period_event_out}, {18'h0, p & en & m});
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      chk({32'h0, s_axi_bresp}, exp_q.pop_front());
    end
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ------------------------------------------
  // Main sequence.
  // ------------------------------------------
  initial begin
    ev_en = $urandom(32'h6fe2a6b7);
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(`RTCIE_IDX_ENCLR, 34'h0);
    rd(`RTCIE_IDX_EVOUT, 34'h0);
    rd(6'h3f, {`RTCIE_RESP_DECERR, 32'h0});
    wr(6'h3f, 32'hff, `RTCIE_RESP_DECERR);
    $display("Test reset done");
    step(`RTCIE_IDX_ENSET, 8'hff, 8'hc1);
    step(`RTCIE_IDX_ENCLR, 8'h00, 8'hc1);
    step(`RTCIE_IDX_ENCLR, 8'h80, 8'h41);
    step(`RTCIE_IDX_ENCLR, 8'h40, 8'h01);
    step(`RTCIE_IDX_ENCLR, 8'h01, 8'h00);
    step(`RTCIE_IDX_ENSET, 8'h80, 8'h80);
    evt(16'h0, 16'h8000, 16'hffff);
    chk({33'h0, irq}, 34'h1);
    step(`RTCIE_IDX_ENCLR, 8'h80, 8'h00);
    chk({33'h0, irq}, 34'h0);
    evt(16'h0, 16'h4000, 16'hffff);
    chk({33'h0, irq}, 34'h0);
    rd(`RTCIE_IDX_FLAG, {26'h0, 8'hc0});
    wr(`RTCIE_IDX_FLAG, 32'hff, `RTCIE_RESP_OKAY);
    $display("Test wide mode done");
    wr(`RTCIE_IDX_CTRL, 32'h4, `RTCIE_RESP_OKAY);
    step(`RTCIE_IDX_ENSET, 8'hff, 8'hc3);
    step(`RTCIE_IDX_ENCLR, 8'h02, 8'hc1);
    step(`RTCIE_IDX_ENCLR, 8'h01, 8'hc0);
    wr(`RTCIE_IDX_WPROT, 32'h1, `RTCIE_RESP_OKAY);
    step(`RTCIE_IDX_ENCLR, 8'hff, 8'hc0);
    wr(`RTCIE_IDX_WPROT, 32'h0, `RTCIE_RESP_OKAY);
    wr(`RTCIE_IDX_CTRL, 32'h8, `RTCIE_RESP_OKAY);
    step(`RTCIE_IDX_ENSET, 8'h01, 8'hc1);
    step(`RTCIE_IDX_ENCLR, 8'h01, 8'hc0);
    $display("Test enable layouts done");
    // The reserved mode code is run as well; it must use the single-channel layout.
    for (int md = 0; md < 4; md++) begin
      ev_m = (md == 1) ? `RTCIE_EVOUT_MASK_TWO : `RTCIE_EVOUT_MASK_ONE;
      ev_en = $urandom;
      wr(`RTCIE_IDX_CTRL, {28'h0, md[1:0], 2'h0}, `RTCIE_RESP_OKAY);
      chk({32'h0, mode_sel}, {32'h0, md[1:0]});
      wr(`RTCIE_IDX_EVOUT, {16'h0, ev_en}, `RTCIE_RESP_OKAY);
      rd(`RTCIE_IDX_EVOUT, {18'h0, ev_en & ev_m});
      repeat (6) evt(ev_en, $urandom, ev_m);
    end
    $display("Test event gating done");
    test_done();
  end
endmodule
`default_nettype wire
